// file: rtl/flash_seq_cfg.svh
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_ERASE_SETUP   8'h20
`define CMD_ERASE_CONFIRM 8'hd0
`define CMD_PROG_SETUP    8'h40
`define CMD_CLEAR_STATUS  8'h50
`define CMD_READ_STATUS   8'h70
`define CMD_READ_ARRAY    8'hff

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define SR_READY_BIT      7
`define SR_ERASE_FAIL_BIT 5
`define SR_PROG_FAIL_BIT  4
`define SR_VPP_LOW_BIT    3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     100
`define UNLOCK_SETUP_NS   480
`define UNLOCK_SETUP_CYC  \
  ((`UNLOCK_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RP_RECOVER_NS     480
`define RP_RECOVER_CYC    \
  ((`RP_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RP_LOW_NS         100
`define RP_LOW_CYC        \
  ((`RP_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC     4

`endif

// file: rtl/flash_seq_pkg.sv
`default_nettype none
package flash_seq_pkg;

  typedef enum logic [2:0] {
    OP_PROGRAM = 3'h0,
    OP_ERASE   = 3'h1,
    OP_CHECK   = 3'h2,
    OP_CLEAR   = 3'h3,
    OP_READ    = 3'h4
  } op_t;

  typedef enum logic [1:0] {
    RP_LOW    = 2'h0,
    RP_HIGH   = 2'h1,
    RP_UNLOCK = 2'h2
  } rp_mode_t;

  typedef struct packed {
    op_t         op;
    logic [16:0] addr;
    logic [7:0]  data;
    logic        boot;
    logic        check_each;
    logic        last;
  } req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       vpp_low;
    logic       prog_fail;
    logic       erase_fail;
    logic       seq_error;
    logic       aborted;
  } resp_t;

endpackage
`default_nettype wire

// file: rtl/flash_program_erase_sequencer.sv
// Operation
// RQ1: Bad command after erase setup sets both fails
// RQ2: Erase is 20H then D0H in block
// RQ3: Power-down low or low voltage aborts operation
// RQ4: Erase or reprogram restores aborted location
// RQ5: Device verifies internally and reports status flags
// RQ6: Boot block changes need unlock high voltage
// RQ7: Locked boot attempt sets matching failure flag
// RQ8: Hold unlock voltage from confirm until ready
// RQ9: Program is 40H then data, same address
// RQ10: Poll status, toggle enables, bit7 means ready
// RQ11: Write FFH after last program or erase
// RQ12: Low voltage flag blocks attempts until cleared
// RQ13: Low voltage flag persists until clear command
// RQ14: Both fails after erase mean sequence error
// RQ15: Erase failure sets bit five
// RQ16: Program verify failure sets program fail flag
// RQ17: Clear status on error before any recovery
// RQ18: Full check per item or after series
// RQ19: Fail flags clear only by 50H command
// RQ20: After 70H reads return status
`include "flash_seq_cfg.svh"
`default_nettype none
module flash_program_erase_sequencer (
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      req_valid_in,
  output logic                           req_ready_out,
  input  wire flash_seq_pkg::req_t       req_in,
  input  wire logic                      abort_in,
  output logic                           resp_valid_out,
  output flash_seq_pkg::resp_t           resp_out,
  output logic [16:0]                    addr_out,
  output logic [7:0]                     data_out,
  output logic                           data_oe_out,
  input  wire logic [7:0]                data_in,
  output logic                           ce_n_out,
  output logic                           oe_n_out,
  output logic                           we_n_out,
  output flash_seq_pkg::rp_mode_t        reset_powerdown_pin_out
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_NEXT = 8'h02,
    S_WSET = 8'h04,
    S_WSTB = 8'h08,
    S_WREC = 8'h10,
    S_RSTB = 8'h20,
    S_RREC = 8'h40,
    S_WAIT = 8'h80
  } state_t;

  state_t               state_q;
  flash_seq_pkg::req_t  req_q;
  flash_seq_pkg::resp_t resp_q;
  logic [2:0]           step_q;
  logic [2:0]           timer_q;
  logic                 unlocked_q;
  logic                 aborting_q;
  logic                 resp_valid_q;
  logic [7:0]           din_meta_q;
  logic [7:0]           din_sync_q;
  logic                 is_alter;
  logic                 has_error;

  assign req_ready_out  = (state_q == S_IDLE);
  assign resp_valid_out = resp_valid_q;
  assign resp_out       = resp_q;
  assign is_alter = (req_q.op == flash_seq_pkg::OP_PROGRAM) ||
                    (req_q.op == flash_seq_pkg::OP_ERASE);
  assign has_error = resp_q.vpp_low | resp_q.prog_fail | resp_q.erase_fail;

  // ----------------------------------------------------------------
  // Data input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      din_meta_q <= 8'h00;
      din_sync_q <= 8'h00;
    end else begin
      din_meta_q <= data_in;
      din_sync_q <= din_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q                 <= S_IDLE;
      req_q                   <= '0;
      resp_q                  <= '0;
      step_q                  <= 3'h0;
      timer_q                 <= 3'h0;
      unlocked_q              <= 1'b0;
      aborting_q              <= 1'b0;
      resp_valid_q            <= 1'b0;
      addr_out                <= 17'h00000;
      data_out                <= 8'h00;
      data_oe_out             <= 1'b0;
      ce_n_out                <= 1'b1;
      oe_n_out                <= 1'b1;
      we_n_out                <= 1'b1;
      reset_powerdown_pin_out <= flash_seq_pkg::RP_HIGH;
    end else begin
      resp_valid_q <= 1'b0;
      if (abort_in && state_q != S_IDLE && !aborting_q) begin
        // Dropping the power-down pin halts the device mid-operation
        reset_powerdown_pin_out <= flash_seq_pkg::RP_LOW; // RQ3
        ce_n_out       <= 1'b1;
        oe_n_out       <= 1'b1;
        we_n_out       <= 1'b1;
        data_oe_out    <= 1'b0;
        aborting_q     <= 1'b1;
        unlocked_q     <= 1'b0;
        resp_q.aborted <= 1'b1;
        step_q         <= 3'h0;
        timer_q        <= 3'(`RP_LOW_CYC);
        state_q        <= S_WAIT;
      end else begin
        unique case (state_q)
          S_IDLE: begin
            if (req_valid_in) begin
              req_q   <= req_in;
              resp_q  <= '0;
              step_q  <= 3'h0;
              state_q <= S_NEXT;
            end
          end
          S_NEXT: begin
            state_q  <= S_WSET;
            addr_out <= req_q.addr;
            unique case (step_q)
              3'h0: begin
                step_q <= 3'h1;
                unique case (req_q.op)
                  flash_seq_pkg::OP_PROGRAM:
                    data_out <= `CMD_PROG_SETUP; // RQ9
                  flash_seq_pkg::OP_ERASE:
                    data_out <= `CMD_ERASE_SETUP; // RQ2
                  flash_seq_pkg::OP_CHECK:
                    data_out <= `CMD_READ_STATUS; // RQ20
                  flash_seq_pkg::OP_CLEAR:
                    data_out <= `CMD_CLEAR_STATUS; // RQ19
                  default: data_out <= `CMD_READ_ARRAY;
                endcase
              end
              3'h1: begin
                if (is_alter && req_q.boot && !unlocked_q) begin
                  // Unlock voltage must settle before the confirm write
                  reset_powerdown_pin_out <= flash_seq_pkg::RP_UNLOCK; // RQ8
                  unlocked_q <= 1'b1;
                  timer_q    <= 3'(`UNLOCK_SETUP_CYC);
                  state_q    <= S_WAIT;
                end else if (req_q.op == flash_seq_pkg::OP_PROGRAM) begin
                  data_out <= req_q.data; // RQ9
                  step_q   <= 3'h2;
                end else if (req_q.op == flash_seq_pkg::OP_ERASE) begin
                  data_out <= `CMD_ERASE_CONFIRM; // RQ2
                  step_q   <= 3'h2;
                end else if (req_q.op == flash_seq_pkg::OP_CHECK) begin
                  step_q  <= 3'h2;
                  state_q <= S_RSTB;
                end else if (req_q.op == flash_seq_pkg::OP_READ) begin
                  step_q  <= 3'h5;
                  state_q <= S_RSTB;
                end else begin
                  step_q  <= 3'h6;
                  state_q <= S_IDLE;
                  resp_valid_q <= 1'b1;
                end
              end
              3'h2: begin
                state_q <= S_RSTB; // RQ10
              end
              3'h3: begin
                // Unlock stays until status has shown ready
                if (unlocked_q) begin
                  reset_powerdown_pin_out <= flash_seq_pkg::RP_HIGH; // RQ8
                  unlocked_q <= 1'b0;
                end
                step_q <= 3'h4;
                if (has_error && (req_q.check_each ||
                    req_q.op == flash_seq_pkg::OP_CHECK)) begin
                  data_out <= `CMD_CLEAR_STATUS; // RQ17
                end else begin
                  state_q <= S_NEXT;
                end
              end
              3'h4: begin
                step_q <= 3'h6;
                if (is_alter && req_q.last) begin
                  data_out <= `CMD_READ_ARRAY; // RQ11
                end else begin
                  state_q      <= S_IDLE;
                  resp_valid_q <= 1'b1;
                end
              end
              default: begin
                state_q      <= S_IDLE;
                resp_valid_q <= 1'b1;
              end
            endcase
          end
          S_WSET: begin
            data_oe_out <= 1'b1;
            ce_n_out    <= 1'b0;
            we_n_out    <= 1'b0;
            state_q     <= S_WSTB;
          end
          S_WSTB: begin
            // Data is latched on this rising edge of the write strobe
            ce_n_out <= 1'b1;
            we_n_out <= 1'b1;
            state_q  <= S_WREC;
          end
          S_WREC: begin
            data_oe_out <= 1'b0;
            if (step_q == 3'h6) begin
              state_q      <= S_IDLE;
              resp_valid_q <= 1'b1;
            end else begin
              state_q <= S_NEXT;
            end
          end
          S_RSTB: begin
            ce_n_out <= 1'b0;
            oe_n_out <= 1'b0;
            if (ce_n_out) begin
              // Covers access time plus the two synchroniser stages
              timer_q <= 3'(`READ_WAIT_CYC);
            end else if (timer_q != 3'h0) begin
              timer_q <= timer_q - 3'h1;
            end else begin
              resp_q.data <= din_sync_q;
              ce_n_out    <= 1'b1;
              oe_n_out    <= 1'b1; // RQ10
              state_q     <= S_RREC;
            end
          end
          S_RREC: begin
            state_q <= S_NEXT;
            if (step_q == 3'h2) begin
              if (resp_q.data[`SR_READY_BIT]) begin // RQ10
                step_q            <= 3'h3;
                resp_q.vpp_low    <= resp_q.data[`SR_VPP_LOW_BIT];
                resp_q.prog_fail  <= resp_q.data[`SR_PROG_FAIL_BIT];
                resp_q.erase_fail <= resp_q.data[`SR_ERASE_FAIL_BIT];
                // Flags accumulate, so a status check as well as an erase
                // can see a pair that came from an erase; a program is excluded
                resp_q.seq_error  <= resp_q.data[`SR_PROG_FAIL_BIT] & // RQ14
                                     resp_q.data[`SR_ERASE_FAIL_BIT] & // RQ18
                                     (req_q.op != flash_seq_pkg::OP_PROGRAM);
              end
            end
          end
          S_WAIT: begin
            if (timer_q != 3'h0) begin
              timer_q <= timer_q - 3'h1;
            end else if (aborting_q &&
                reset_powerdown_pin_out == flash_seq_pkg::RP_LOW) begin
              reset_powerdown_pin_out <= flash_seq_pkg::RP_HIGH;
              timer_q <= 3'(`RP_RECOVER_CYC);
            end else if (aborting_q) begin
              aborting_q   <= 1'b0;
              state_q      <= S_IDLE;
              resp_valid_q <= 1'b1;
            end else begin
              state_q <= S_NEXT;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // flash_program_erase_sequencer
`default_nettype wire

// file: test/flash_seq_props.sv
`default_nettype none
module flash_seq_props (
  input wire logic                    ref_clk_in,
  input wire logic                    rst_in,
  input wire logic                    req_ready_out,
  input wire logic                    abort_in,
  input wire logic                    resp_valid_out,
  input wire flash_seq_pkg::resp_t    resp_out,
  input wire logic                    data_oe_out,
  input wire logic                    ce_n_out,
  input wire logic                    oe_n_out,
  input wire logic                    we_n_out,
  input wire flash_seq_pkg::rp_mode_t reset_powerdown_pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_wr_drive; !we_n_out |-> data_oe_out && !ce_n_out; endproperty
  a_wr_drive: assert property (p_wr_drive)
    else $error("write strobe without bus drive");
  property p_we_pulse; !we_n_out |=> we_n_out; endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("write strobe longer than one cycle");
  property p_rd_bus; !oe_n_out |-> !data_oe_out && !ce_n_out; endproperty
  a_rd_bus: assert property (p_rd_bus)
    else $error("read while driving the bus");
  property p_oe_toggle; $rose(oe_n_out) |=> oe_n_out; endproperty
  a_oe_toggle: assert property (p_oe_toggle)
    else $error("read strobe not toggled high");
  property p_seq_err; resp_valid_out && resp_out.seq_error
    |-> resp_out.prog_fail && resp_out.erase_fail; endproperty
  a_seq_err: assert property (p_seq_err)
    else $error("sequence error without both fails");
  property p_abort_rp; $rose(abort_in) && !req_ready_out |-> ##[0:3]
    reset_powerdown_pin_out == flash_seq_pkg::RP_LOW; endproperty
  a_abort_rp: assert property (p_abort_rp)
    else $error("abort did not pull power-down low");
  property p_abort_resp; reset_powerdown_pin_out == flash_seq_pkg::RP_LOW
    |-> ##[1:12] resp_valid_out && resp_out.aborted; endproperty
  a_abort_resp: assert property (p_abort_resp)
    else $error("abort not reported");
  property p_unlock;
    $rose(reset_powerdown_pin_out == flash_seq_pkg::RP_UNLOCK)
    |-> (reset_powerdown_pin_out == flash_seq_pkg::RP_UNLOCK)[*6]; endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock voltage dropped early");
endmodule // flash_seq_props
bind flash_program_erase_sequencer flash_seq_props u_props (
  .ref_clk_in, .rst_in, .req_ready_out, .abort_in, .resp_valid_out,
  .resp_out, .data_oe_out, .ce_n_out, .oe_n_out, .we_n_out,
  .reset_powerdown_pin_out);
`default_nettype wire

// file: test/flash_model.sv
`default_nettype none
module flash_model #(parameter int BUSY_CYC = 30) (
  input  wire logic                    clk_in,
  input  wire logic [16:0]             addr_in,
  input  wire logic [7:0]              dq_in,
  input  wire logic                    ce_n_in,
  input  wire logic                    oe_n_in,
  input  wire logic                    we_n_in,
  input  wire flash_seq_pkg::rp_mode_t rp_in,
  input  wire logic                    vpp_bad_in,
  input  wire logic                    fail_in,
  output logic [7:0]                   dq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [logic [16:0]];
  logic [7:0]  rd_q = 8'h00;
  logic [16:0] sa_q = '0;
  logic [1:0]  mode_q = 2'h0;
  logic [2:0]  flag_q = 3'h0;
  int          cnt_q = 0;
  wire logic [7:0] sr = {cnt_q == 0, 1'b0, flag_q, 3'h0};
  function automatic logic [7:0] rdm(logic [16:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  // Released bus shows the inverse of the last value
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd_q : ~rd_q;
  always @(negedge oe_n_in) begin
    rd_q <= (mode_q != 2'h0) ? sr : rdm(addr_in);
  end
  always @(posedge clk_in) begin
    if (cnt_q > 0) cnt_q <= cnt_q - 1;
    if (rp_in == flash_seq_pkg::RP_LOW) begin
      // Aborted byte keeps some bits unprogrammed
      if (cnt_q > 0 && mem.exists(sa_q)) mem[sa_q] = mem[sa_q] | 8'h0f;
      cnt_q <= 0;
      mode_q <= 2'h0;
    end else if (!we_n_in && !ce_n_in && mode_q[1]) begin
      mode_q <= 2'h1;
      cnt_q <= BUSY_CYC;
      if (mode_q == 2'h2 && (dq_in != 8'hd0 ||
          addr_in[16:13] != sa_q[16:13])) flag_q[2:1] <= 2'h3;
      else if (flag_q[0] || vpp_bad_in || fail_in || (addr_in[16:13] == 4'h0
          && rp_in != flash_seq_pkg::RP_UNLOCK)) begin
        flag_q[0] <= flag_q[0] | vpp_bad_in;
        flag_q[mode_q[0] ? 1 : 2] <= 1'b1;
      end else if (!mode_q[0]) begin
        // Only the addressed block returns to the erased value
        foreach (mem[k])
          if (k[16:13] == addr_in[16:13]) mem[k] = 8'hff;
      end else mem[addr_in] = rdm(addr_in) & dq_in;
    end else if (!we_n_in && !ce_n_in) begin
      mode_q <= (dq_in == 8'hff) ? 2'h0 : (dq_in == 8'h20) ? 2'h2 :
                (dq_in == 8'h40) ? 2'h3 : 2'h1;
      sa_q <= addr_in;
      if (dq_in == 8'h50) flag_q <= 3'h0;
    end
  end
endmodule // flash_model
`default_nettype wire

// file: test/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam flash_seq_pkg::op_t pg = flash_seq_pkg::OP_PROGRAM;
  localparam flash_seq_pkg::op_t er = flash_seq_pkg::OP_ERASE;
  localparam flash_seq_pkg::op_t ck = flash_seq_pkg::OP_CHECK;
  localparam flash_seq_pkg::op_t cl = flash_seq_pkg::OP_CLEAR;
  localparam flash_seq_pkg::op_t rd = flash_seq_pkg::OP_READ;
  logic                    ref_clk_in = 1'b0, rst_in = 1'b1;
  logic                    req_valid_in = 1'b0, abort_in = 1'b0;
  logic                    vpp_bad = 1'b0, fail = 1'b0;
  logic                    req_ready_out, resp_valid_out, data_oe_out;
  logic                    ce_n_out, oe_n_out, we_n_out;
  logic [16:0]             addr_out, a;
  logic [7:0]              data_out, dq, d;
  logic [31:0]             rnd = 32'hf476d8cf;
  int                      bad_count = 0, total_checks = 0;
  flash_seq_pkg::req_t     req_in = '0;
  flash_seq_pkg::resp_t    resp_out, rsp;
  flash_seq_pkg::rp_mode_t reset_powerdown_pin_out;
  wire logic [7:0]         data_in = data_oe_out ? data_out : dq;
  flash_program_erase_sequencer uut (.*);
  flash_model dev (.clk_in(ref_clk_in), .addr_in(addr_out), .dq_in(data_in),
    .ce_n_in(ce_n_out), .oe_n_in(oe_n_out), .we_n_in(we_n_out),
    .rp_in(reset_powerdown_pin_out), .vpp_bad_in(vpp_bad),
    .fail_in(fail), .dq_out(dq));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Flags compared as {vpp_low, prog_fail, erase_fail, seq_error, aborted}
  task automatic st(flash_seq_pkg::op_t op, logic [16:0] ad, logic [7:0] dt,
                    logic [1:0] bc, logic [1:0] vf, logic [4:0] e);
    @(negedge ref_clk_in);
    {vpp_bad, fail} = vf;
    req_in = '{op, ad, dt, bc[1], bc[0], 1'b1};
    req_valid_in = 1'b1;
    while (req_ready_out !== 1'b1) @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
    for (int i = 0; i < 3000 && resp_valid_out !== 1'b1; i++)
      @(negedge ref_clk_in);
    chk("resp_valid", 8'h01, {7'h00, resp_valid_out});
    rsp = resp_out;
    if (op != rd) chk("flags", {3'h0, e}, {3'h0, rsp[4:0]});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial forever #50 ref_clk_in = ~ref_clk_in;
  initial begin
    #3000000;
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rst_in = 1'b0;
    st(cl, 17'h04000, 8'h00, 2'h1, 2'h0, 5'h00);
    st(er, 17'h04000, 8'h00, 2'h1, 2'h0, 5'h00);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      a = {4'h1 + i[3:0], rnd[12:0]};
      d = (i == 0) ? 8'h00 : rnd[20:13];
      st(pg, a, d, 2'h1, 2'h0, 5'h00);
      chk("ready", 8'h80, rsp.data & 8'h80);
      st(rd, a, 8'h00, 2'h0, 2'h0, 5'h00);
      chk("array", d, rsp.data);
    end
    st(pg, 17'h00010, 8'h3c, 2'h1, 2'h0, 5'h08);
    st(er, 17'h00010, 8'h00, 2'h1, 2'h0, 5'h04);
    st(pg, 17'h00010, 8'h3c, 2'h3, 2'h0, 5'h00);
    st(rd, 17'h00010, 8'h00, 2'h0, 2'h0, 5'h00);
    chk("boot", 8'h3c, rsp.data);
    st(er, 17'h08000, 8'h00, 2'h1, 2'h1, 5'h04);
    st(pg, 17'h08000, 8'h11, 2'h0, 2'h1, 5'h08);
    st(er, 17'h08000, 8'h00, 2'h0, 2'h0, 5'h08);
    st(ck, 17'h08000, 8'h00, 2'h1, 2'h0, 5'h08);
    st(ck, 17'h08000, 8'h00, 2'h1, 2'h0, 5'h00);
    st(pg, 17'h0a000, 8'h22, 2'h0, 2'h2, 5'h18);
    st(er, 17'h0a000, 8'h00, 2'h0, 2'h0, 5'h1e);
    st(ck, 17'h0a000, 8'h00, 2'h1, 2'h0, 5'h1e);
    st(ck, 17'h0a000, 8'h00, 2'h1, 2'h0, 5'h00);
    fork
      st(pg, 17'h0c000, 8'h5a, 2'h1, 2'h0, 5'h01);
      begin
        repeat (14) @(negedge ref_clk_in);
        abort_in = 1'b1;
      end
    join
    abort_in = 1'b0;
    st(pg, 17'h0c000, 8'h5a, 2'h1, 2'h0, 5'h00);
    st(rd, 17'h0c000, 8'h00, 2'h0, 2'h0, 5'h00);
    chk("restored", 8'h5a, rsp.data);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
